// >>> src/atc_consts.vh
// Constants for the acquisition trigger control block
`ifndef ATC_CONSTS_VH
`define ATC_CONSTS_VH

// Clock period and spike stretcher timing
`define ATC_CLK_PERIOD_PS  4000
`define ATC_SPIKE_MIN_PS   500
`define ATC_SPIKE_CYC      ((`ATC_SPIKE_MIN_PS + `ATC_CLK_PERIOD_PS - 1) / `ATC_CLK_PERIOD_PS)

// Trigger level limit in 0.1 percent of channel_full_scale (0.6 of full scale)
`define ATC_LEVEL_LIM      12'sh258

// Position step and post-trigger maximum (200 million samples)
`define ATC_POS_STEP       32'h00000010
`define ATC_POS_HALF       32'h00000008
`define ATC_POS_MASK       32'hFFFFFFF0
`define ATC_POST_MAX       28'hBEBC200

// Multi-source combine functions
`define ATC_OP_AND         2'h0
`define ATC_OP_OR          2'h1
`define ATC_OP_NAND        2'h2
`define ATC_OP_NOR         2'h3

// Sampling clock modes
`define ATC_CLK_INT        2'h0
`define ATC_CLK_CONT       2'h1
`define ATC_CLK_STARTSTOP  2'h2

// Comparator channel indices
`define ATC_CMP_MAIN       0
`define ATC_CMP_LO         1
`define ATC_CMP_HI         2
`define ATC_CMP_EXT        3
`define ATC_NUM_CMP        4

// Reset values
`define ATC_RST_LEVEL      12'h000
`define ATC_RST_CNT        28'h0000000

`endif

// >>> src/atc_edge_det.v
// Registered rising and falling edge detector for one comparator output
`timescale 1ns/1ps
`default_nettype none

module atc_edge_det (
	// Clock and reset
	input  wire core_clk_i,
	input  wire rst_b_i,
	// Comparator level
	input  wire cmp_i,
	// Detected state and edges
	output reg  level_o,
	output reg  rise_o,
	output reg  fall_o
);

	// Previous level and one-cycle edge pulses
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			level_o <= 1'b0;
			rise_o  <= 1'b0;
			fall_o  <= 1'b0;
		end else begin
			level_o <= cmp_i;
			rise_o  <= cmp_i & ~level_o;
			fall_o  <= ~cmp_i & level_o;
		end
	end

endmodule // atc_edge_det

`default_nettype wire

// >>> src/atc_trig_ctrl.v
// Trigger qualification, positioning and status for the digitizer
//
// Overview of operation
// - Clamp level to midpoint plus/minus 0.6 scale
// - Positive slope rises, negative slope falls
// - Window mode fires on leaving or entering
// - Window is OR of opposite-slope edges
// - Divide-by-four mode fires every fourth rise
// - Divide-by-four mode disables window mode
// - Stretch sub-nanosecond spikes into triggers
// - Spike mode forces positive slope
// - Multi-source combines with AND/OR/NAND/NOR
// - Multi-source fires on false-to-true change
// - Pre-trigger up to full record length
// - Post-trigger delay up to 200 million samples
// - Full pre-trigger puts trigger at last sample
// - Zero position puts trigger at first sample
// - Post delay waits before storing record
// - Position moves only in 16-sample steps
// - Signed position: positive post, negative pre
// - Indicator green while armed and waiting
// - Indicator red when record awaits readout
// - Software may override indicator colour
// - Continuous or start/stop external clock pacing
`timescale 1ns/1ps
`default_nettype none
`include "atc_consts.vh"

module atc_trig_ctrl (
	// Clock and reset
	input  wire        core_clk_i,
	input  wire        rst_b_i,
	// Comparator outputs, synchronous to the clock
	input  wire        cmp_main_i,
	input  wire        cmp_win_lo_i,
	input  wire        cmp_win_hi_i,
	input  wire        cmp_ext_i,
	input  wire        spike_catch_i,
	// Trigger configuration
	input  wire        src_ext_i,
	input  wire        slope_neg_i,
	input  wire        ext_slope_neg_i,
	input  wire        window_en_i,
	input  wire        window_enter_i,
	input  wire        divide_by_four_edge_mode_i,
	input  wire        spike_en_i,
	input  wire        multi_en_i,
	input  wire [1:0]  multi_op_i,
	input  wire [11:0] level_req_i,
	// Position and record length
	input  wire [31:0] trig_pos_i,
	input  wire [27:0] rec_len_i,
	// Sequencing
	input  wire        arm_i,
	input  wire        abort_i,
	input  wire        readout_ack_i,
	// Sample pacing
	input  wire [1:0]  clk_mode_i,
	input  wire        int_tick_i,
	input  wire        ext_tick_i,
	// Indicator override
	input  wire        led_ovr_en_i,
	input  wire [2:0]  led_ovr_rgb_i,
	// Level outputs
	output reg  [11:0] trig_level_o,
	output reg         level_clip_o,
	// Sequencer outputs
	output reg         armed_o,
	output reg         done_o,
	output reg         trig_o,
	output reg  [27:0] trig_idx_o,
	output reg         store_en_o,
	output wire        sample_we_o,
	output reg  [1:0]  clk_sel_o,
	// Indicator colour
	output reg         led_red_o,
	output reg         led_green_o,
	output reg         led_blue_o
);

	// Sequencer states
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_ARMED = 3'h1;
	localparam [2:0] S_DELAY = 3'h2;
	localparam [2:0] S_POST  = 3'h3;
	localparam [2:0] S_DONE  = 3'h4;

	// Comparator edge detection, one detector per input
	wire [`ATC_NUM_CMP-1:0] cmp_in;
	wire [`ATC_NUM_CMP-1:0] lvl;
	wire [`ATC_NUM_CMP-1:0] rise;
	wire [`ATC_NUM_CMP-1:0] fall;

	assign cmp_in = {cmp_ext_i, cmp_win_hi_i, cmp_win_lo_i, cmp_main_i};

	genvar gi;
	generate
		for (gi = 0; gi < `ATC_NUM_CMP; gi = gi + 1) begin : g_edge
			atc_edge_det u_edge (
				.core_clk_i (core_clk_i),
				.rst_b_i    (rst_b_i),
				.cmp_i      (cmp_in[gi]),
				.level_o    (lvl[gi]),
				.rise_o     (rise[gi]),
				.fall_o     (fall[gi])
			);
		end
	endgenerate

	// Trigger level clamp against the allowed band around midpoint
	wire signed [11:0] level_s;
	assign level_s = level_req_i;

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trig_level_o <= `ATC_RST_LEVEL;
			level_clip_o <= 1'b0;
		end else if (level_s > `ATC_LEVEL_LIM) begin
			trig_level_o <= `ATC_LEVEL_LIM;
			level_clip_o <= 1'b1;
		end else if (level_s < -`ATC_LEVEL_LIM) begin
			trig_level_o <= -`ATC_LEVEL_LIM;
			level_clip_o <= 1'b1;
		end else begin
			trig_level_o <= level_req_i;
			level_clip_o <= 1'b0;
		end
	end

	// Mode decode: multi over spike over divide-by-four over window over edge
	wire mode_multi;
	wire mode_spike;
	wire mode_div4;
	wire mode_win;

	assign mode_multi = multi_en_i;
	assign mode_spike = ~multi_en_i & spike_en_i;
	assign mode_div4  = ~multi_en_i & ~spike_en_i & divide_by_four_edge_mode_i;
	assign mode_win   = ~multi_en_i & ~spike_en_i & ~divide_by_four_edge_mode_i & window_en_i;

	// Plain edge trigger on the selected source
	wire edge_rise;
	wire edge_fall;
	wire edge_ev;

	assign edge_rise = src_ext_i ? rise[`ATC_CMP_EXT] : rise[`ATC_CMP_MAIN];
	assign edge_fall = src_ext_i ? fall[`ATC_CMP_EXT] : fall[`ATC_CMP_MAIN];
	assign edge_ev   = slope_neg_i ? edge_fall : edge_rise;

	// Window trigger from two opposite-slope edges
	wire win_exit_ev;
	wire win_enter_ev;
	wire win_ev;

	assign win_exit_ev  = fall[`ATC_CMP_LO] | rise[`ATC_CMP_HI];
	assign win_enter_ev = rise[`ATC_CMP_LO] | fall[`ATC_CMP_HI];
	assign win_ev       = window_enter_i ? win_enter_ev : win_exit_ev;

	// Divide-by-four counter of positive edges
	reg  [1:0] div_cnt_q;
	wire [1:0] div_cnt_d;
	wire       div_ev;

	assign div_ev    = mode_div4 & rise[`ATC_CMP_MAIN] & (div_cnt_q == 2'h3);
	assign div_cnt_d = (mode_div4 & rise[`ATC_CMP_MAIN]) ? div_cnt_q + 2'h1 : div_cnt_q;

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_cnt_q <= 2'h0;
		end else if (!mode_div4) begin
			div_cnt_q <= 2'h0;
		end else begin
			div_cnt_q <= div_cnt_d;
		end
	end

	// Spike stretcher: hold a caught spike long enough to be seen
	reg  [2:0]  str_cnt_q;
	reg         str_prev_q;
	wire        str_lvl;
	wire        spike_ev;
	wire [31:0] str_len;

	// Stretch length kept as a full word, cut to the counter width below
	assign str_len  = `ATC_SPIKE_CYC + 1;
	assign str_lvl  = (str_cnt_q != 3'h0);
	assign spike_ev = str_lvl & ~str_prev_q;

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			str_cnt_q  <= 3'h0;
			str_prev_q <= 1'b0;
		end else begin
			str_prev_q <= str_lvl;
			if (mode_spike & spike_catch_i) begin
				str_cnt_q <= str_len[2:0];
			end else if (str_lvl) begin
				str_cnt_q <= str_cnt_q - 3'h1;
			end
		end
	end

	// Multi-source pattern: true/false per input, combined, rising edge only
	wire cond_ch;
	wire cond_ext;
	reg  comb_d;
	reg  comb_q;
	wire multi_ev;

	assign cond_ch  = slope_neg_i ? ~lvl[`ATC_CMP_MAIN] : lvl[`ATC_CMP_MAIN];
	assign cond_ext = ext_slope_neg_i ? ~lvl[`ATC_CMP_EXT] : lvl[`ATC_CMP_EXT];

	always @* begin
		case (multi_op_i)
			`ATC_OP_AND:  comb_d = cond_ch & cond_ext;
			`ATC_OP_OR:   comb_d = cond_ch | cond_ext;
			`ATC_OP_NAND: comb_d = ~(cond_ch & cond_ext);
			default:      comb_d = ~(cond_ch | cond_ext);
		endcase
	end

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			comb_q <= 1'b0;
		end else begin
			comb_q <= comb_d;
		end
	end

	assign multi_ev = comb_d & ~comb_q;

	// Selected trigger event
	wire trig_ev;

	assign trig_ev = mode_multi ? multi_ev :
	                 mode_spike ? spike_ev :
	                 mode_div4  ? div_ev   :
	                 mode_win   ? win_ev   : edge_ev;

	// Sample pacing by clock mode
	wire tick;

	assign tick = (clk_mode_i == `ATC_CLK_INT) ? int_tick_i : ext_tick_i;

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_sel_o <= `ATC_CLK_INT;
		end else begin
			clk_sel_o <= clk_mode_i;
		end
	end

	// Position rounding to the nearest step and limiting
	wire [31:0] pos_rnd;
	wire [31:0] pre_mag;
	wire [27:0] pre_lim;
	wire [27:0] post_lim;
	wire        pos_neg;

	assign pos_rnd  = (trig_pos_i + `ATC_POS_HALF) & `ATC_POS_MASK;
	assign pos_neg  = pos_rnd[31];
	assign pre_mag  = pos_neg ? (32'h0 - pos_rnd) : 32'h0;
	assign pre_lim  = (pre_mag > {4'h0, rec_len_i}) ? rec_len_i : pre_mag[27:0];
	assign post_lim = pos_neg ? 28'h0 :
	                  (pos_rnd > {4'h0, `ATC_POST_MAX}) ? `ATC_POST_MAX : pos_rnd[27:0];

	// Sequencer registers
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [27:0] pre_q;
	reg  [27:0] post_q;
	reg  [27:0] len_q;
	reg  [27:0] fill_q;
	reg  [27:0] cnt_q;
	reg  [27:0] cnt_d;
	reg         trig_d;

	wire        arm_ok;
	wire        take_trig;
	wire [27:0] after_len;

	assign arm_ok    = (state_q == S_ARMED) && (fill_q >= pre_q);
	assign take_trig = arm_ok & trig_ev;
	assign after_len = len_q - pre_q;

	// Next state and counter
	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q;
		trig_d  = 1'b0;
		case (state_q)
			S_IDLE: begin
				if (arm_i) begin
					state_d = S_ARMED;
				end
			end
			S_ARMED: begin
				if (take_trig) begin
					trig_d = 1'b1;
					if (post_q != 28'h0) begin
						state_d = S_DELAY;
						cnt_d   = post_q;
					end else if (after_len == 28'h0) begin
						state_d = S_DONE;
					end else begin
						state_d = S_POST;
						cnt_d   = after_len;
					end
				end
			end
			S_DELAY: begin
				if (tick) begin
					cnt_d = cnt_q - 28'h1;
					if (cnt_q == 28'h1) begin
						state_d = S_POST;
						cnt_d   = len_q;
					end
				end
			end
			S_POST: begin
				if (tick) begin
					cnt_d = cnt_q - 28'h1;
					if (cnt_q == 28'h1) begin
						state_d = S_DONE;
					end
				end
			end
			S_DONE: begin
				if (readout_ack_i) begin
					state_d = S_IDLE;
				end else if (arm_i) begin
					state_d = S_ARMED;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
		if (abort_i) begin
			state_d = S_IDLE;
		end
	end

	// State, position latch and pre-trigger fill count
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= S_IDLE;
			pre_q   <= `ATC_RST_CNT;
			post_q  <= `ATC_RST_CNT;
			len_q   <= `ATC_RST_CNT;
			fill_q  <= `ATC_RST_CNT;
			cnt_q   <= `ATC_RST_CNT;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			if (state_d == S_ARMED && state_q != S_ARMED) begin
				pre_q  <= pre_lim;
				post_q <= post_lim;
				len_q  <= rec_len_i;
				fill_q <= `ATC_RST_CNT;
			end else if (state_q == S_ARMED && tick && fill_q < pre_q) begin
				fill_q <= fill_q + 28'h1;
			end
		end
	end

	// Trigger pulse, trigger index in record and storage enable
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trig_o     <= 1'b0;
			trig_idx_o <= `ATC_RST_CNT;
			store_en_o <= 1'b0;
			armed_o    <= 1'b0;
			done_o     <= 1'b0;
		end else begin
			trig_o     <= trig_d;
			armed_o    <= (state_d == S_ARMED);
			done_o     <= (state_d == S_DONE);
			store_en_o <= ((state_d == S_ARMED) && (pre_q != 28'h0) && (state_q == S_ARMED)) ||
			              (state_d == S_POST);
			if (trig_d) begin
				if (post_q != 28'h0) begin
					trig_idx_o <= `ATC_RST_CNT;
				end else if (pre_q == len_q && len_q != 28'h0) begin
					trig_idx_o <= len_q - 28'h1;
				end else begin
					trig_idx_o <= pre_q;
				end
			end
		end
	end

	// Sample write strobe on each paced sample while storing
	assign sample_we_o = store_en_o & tick;

	// Status indicator with software override
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			led_red_o   <= 1'b0;
			led_green_o <= 1'b0;
			led_blue_o  <= 1'b0;
		end else if (led_ovr_en_i) begin
			led_red_o   <= led_ovr_rgb_i[2];
			led_green_o <= led_ovr_rgb_i[1];
			led_blue_o  <= led_ovr_rgb_i[0];
		end else begin
			led_red_o   <= (state_d == S_DONE);
			led_green_o <= (state_d == S_ARMED);
			led_blue_o  <= 1'b0;
		end
	end

endmodule // atc_trig_ctrl

`default_nettype wire

// >>> tb/atc_cmp_model.sv
// Comparator and spike latch model that feeds the trigger block
`timescale 1ns/1ps
`default_nettype none

module atc_cmp_model #(
	parameter logic signed [11:0] LVL = 12'sh000,
	parameter logic signed [11:0] LO  = 12'shF9C,
	parameter logic signed [11:0] HI  = 12'sh064
) (
	// Clock and analog levels
	input  wire logic               core_clk_i,
	input  wire logic signed [11:0] sig_i,
	input  wire logic signed [11:0] ext_i,
	input  wire logic               spk_i,
	// Comparator outputs
	output var  logic               main_o,
	output var  logic               lo_o,
	output var  logic               hi_o,
	output var  logic               ext_o,
	output var  logic               spk_o
);
	logic spk_q;

	// Comparators resolve once a sample; the spike latch flags only a fresh request
	always @(posedge core_clk_i) begin
		main_o <= sig_i > LVL;
		lo_o   <= sig_i > LO;
		hi_o   <= sig_i > HI;
		ext_o  <= ext_i > LVL;
		spk_q  <= spk_i;
		spk_o  <= spk_i & ~spk_q;
	end
endmodule // atc_cmp_model

`default_nettype wire

// >>> tb/atc_trig_ctrl_asserts.sv
// Port checker for the acquisition trigger control block
`timescale 1ns/1ps
`default_nettype none

module atc_trig_ctrl_asserts (
	// Clock and reset
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	// Watched ports
	input wire logic [11:0] level_req_i,
	input wire logic [11:0] trig_level_o,
	input wire logic        level_clip_o,
	input wire logic        armed_o,
	input wire logic        done_o,
	input wire logic        trig_o,
	input wire logic        store_en_o,
	input wire logic        sample_we_o,
	input wire logic [1:0]  clk_mode_i,
	input wire logic [1:0]  clk_sel_o,
	input wire logic        led_ovr_en_i,
	input wire logic [2:0]  led_ovr_rgb_i,
	input wire logic        led_red_o,
	input wire logic        led_green_o,
	input wire logic        led_blue_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	lvl_high_clamp_a: assert property ($signed(level_req_i) > 12'sh258 |=> trig_level_o == 12'h258 && level_clip_o)
		else $error("level not clamped high");
	lvl_low_clamp_a: assert property ($signed(level_req_i) < 12'shDA8 |=> trig_level_o == 12'hDA8 && level_clip_o)
		else $error("level not clamped low");
	lvl_pass_a: assert property ($signed(level_req_i) <= 12'sh258 && $signed(level_req_i) >= 12'shDA8
		|=> trig_level_o == $past(level_req_i) && !level_clip_o) else $error("level altered in range");
	trig_armed_a: assert property (trig_o |-> $past(armed_o) && !armed_o)
		else $error("trigger outside armed state");
	trig_single_a: assert property (trig_o |=> !trig_o)
		else $error("trigger pulse too long");
	green_armed_a: assert property (!$past(led_ovr_en_i) |-> led_green_o == armed_o)
		else $error("green does not follow armed");
	red_done_a: assert property (!$past(led_ovr_en_i) |-> led_red_o == done_o)
		else $error("red does not follow done");
	led_ovr_a: assert property ($past(led_ovr_en_i) |-> {led_red_o, led_green_o, led_blue_o} == $past(led_ovr_rgb_i))
		else $error("override colour not shown");
	clk_sel_a: assert property (1'b1 |-> clk_sel_o == $past(clk_mode_i))
		else $error("clock select wrong");
	we_store_a: assert property (sample_we_o |-> store_en_o)
		else $error("write outside store window");
	done_quiet_a: assert property ($rose(done_o) |-> !store_en_o && !armed_o)
		else $error("done while storing");

	// Main scenarios reached
	cover property (trig_o);
	cover property ($rose(done_o));
	cover property (level_clip_o);
endmodule // atc_trig_ctrl_asserts

bind atc_trig_ctrl atc_trig_ctrl_asserts u_chk (.core_clk_i, .rst_b_i, .level_req_i, .trig_level_o, .level_clip_o,
	.armed_o, .done_o, .trig_o, .store_en_o, .sample_we_o, .clk_mode_i, .clk_sel_o, .led_ovr_en_i, .led_ovr_rgb_i,
	.led_red_o, .led_green_o, .led_blue_o);

`default_nettype wire

// >>> tb/atc_trig_ctrl_tb.sv
// Self-checking testbench for the acquisition trigger control block
`timescale 1ns/1ps
`default_nettype none

module atc_trig_ctrl_tb;
	localparam logic signed [11:0] L = 12'shE00;
	localparam logic signed [11:0] H = 12'sh200;
	localparam logic signed [11:0] M = 12'sh000;
	logic               core_clk_i = 1'b0;
	logic               rst_b_i = 1'b0;
	logic [5:0]         md = 6'h00;
	logic [1:0]         op = 2'h0;
	logic [1:0]         clk_mode = 2'h0;
	logic               arm = 1'b0, abort = 1'b0, ack = 1'b0, tick = 1'b0, spk = 1'b0, ovr = 1'b0;
	logic [2:0]         rgb = 3'h0;
	logic [11:0]        lvl = 12'h000;
	logic signed [11:0] sig = 12'shE00, ext = 12'shE00;
	logic [31:0]        pos = 32'h00000000;
	logic [27:0]        len = 28'h0000002;
	logic               main_c, lo_c, hi_c, ext_c, spk_c, armed, done, trig, store, we, clip, red, grn, blu;
	logic [11:0]        tlvl;
	logic [27:0]        idx;
	logic [1:0]         csel;
	logic signed [11:0] ma [4] = '{L, L, H, H};
	logic signed [11:0] ea [4] = '{L, L, H, H};
	logic signed [11:0] mb [4] = '{H, H, L, L};
	logic signed [11:0] eb [4] = '{H, L, H, L};
	int                 num_errors = 0, n_compared = 0, hits = 0;

	// Sample clock
	always #2 core_clk_i = ~core_clk_i;

	// Far-side comparators
	atc_cmp_model u_cmp (.core_clk_i(core_clk_i), .sig_i(sig), .ext_i(ext), .spk_i(spk), .main_o(main_c),
		.lo_o(lo_c), .hi_o(hi_c), .ext_o(ext_c), .spk_o(spk_c));

	atc_trig_ctrl dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cmp_main_i(main_c), .cmp_win_lo_i(lo_c),
		.cmp_win_hi_i(hi_c), .cmp_ext_i(ext_c), .spike_catch_i(spk_c), .src_ext_i(1'b0), .slope_neg_i(md[0]),
		.ext_slope_neg_i(1'b0), .window_en_i(md[2]), .window_enter_i(md[1]), .divide_by_four_edge_mode_i(md[3]),
		.spike_en_i(md[4]), .multi_en_i(md[5]), .multi_op_i(op), .level_req_i(lvl), .trig_pos_i(pos),
		.rec_len_i(len), .arm_i(arm), .abort_i(abort), .readout_ack_i(ack), .clk_mode_i(clk_mode),
		.int_tick_i(tick), .ext_tick_i(tick), .led_ovr_en_i(ovr), .led_ovr_rgb_i(rgb), .trig_level_o(tlvl),
		.level_clip_o(clip), .armed_o(armed), .done_o(done), .trig_o(trig), .trig_idx_o(idx), .store_en_o(store),
		.sample_we_o(we), .clk_sel_o(csel), .led_red_o(red), .led_green_o(grn), .led_blue_o(blu));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One clock, inputs moved just after the edge, trigger pulses tallied
	task automatic step;
		@(posedge core_clk_i);
		#1;
		if (trig === 1'b1)
			hits++;
	endtask

	// Arm, lead in, move the source, then judge trigger and record shape
	task automatic trial(input logic [5:0] m, input logic [31:0] p, input logic [27:0] n, input int lead,
		input logic signed [11:0] am, ae, bm, be, input int ntrig, input logic [27:0] eidx, input int nwe, ngap);
		int cwe = 0;
		int cgap = 0;
		md = m; pos = p; len = n; sig = am; ext = ae; spk = 1'b0; tick = lead > 0;
		step;
		step;
		arm = 1'b1;
		step;
		arm = 1'b0;
		chk("armed", armed, 1);
		repeat (lead) step;
		hits = 0;
		sig = bm; ext = be; spk = m[4];
		for (int i = 0; i < 8 && hits == 0; i++) step;
		chk("trigger", hits, ntrig);
		if (hits == 0) begin
			abort = 1'b1;
			step;
			abort = 1'b0;
			return;
		end
		chk("index", idx, eidx);
		tick = 1'b1;
		for (int i = 0; i < 60 && done !== 1'b1; i++) begin
			#1;
			if (we === 1'b1) cwe++; else cgap++;
			step;
		end
		chk("done", done, 1);
		if (done !== 1'b1) wrap_up;
		chk("red", red, 1);
		chk("stored", cwe, nwe);
		chk("delay", cgap, ngap);
		chk("one trigger", hits, 1);
		ack = 1'b1;
		step;
		ack = 0;
	endtask

	// Level clamp table and indicator override
	task automatic s_level;
		logic [11:0] v [3] = '{12'h300, 12'hC00, 12'h123};
		logic [11:0] e [3] = '{12'h258, 12'hDA8, 12'h123};
		for (int i = 0; i < 3; i++) begin
			lvl = v[i];
			step;
			chk("level", {tlvl, clip}, {e[i], i < 2});
		end
		ovr = 1'b1;
		rgb = 3'h5;
		step;
		chk("led", {red, grn, blu}, 3'h5);
		ovr = 1'b0;
		step;
	endtask

	// Divide-by-four with window also requested: only the fourth rise fires
	task automatic s_div4;
		md = 6'h0C; pos = 0; len = 2; sig = L; tick = 1'b0;
		step;
		arm = 1'b1;
		step;
		arm = 1'b0;
		hits = 0;
		for (int k = 0; k < 4; k++) begin
			chk("div4 early", hits, 0);
			sig = H;
			repeat (3) step;
			sig = L;
			repeat (2) step;
		end
		chk("div4 fire", hits, 1);
		abort = 1'b1;
		step;
		abort = 1'b0;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge core_clk_i);
		#1;
		rst_b_i = 1'b1;
		s_level;
		trial(6'h00, 0, 2, 0, L, L, H, L, 1, 0, 2, 0);
		trial(6'h01, 0, 2, 0, H, L, L, L, 1, 0, 2, 0);
		trial(6'h00, 0, 2, 0, H, L, L, L, 0, 0, 0, 0);
		trial(6'h06, 0, 2, 0, H, L, M, L, 1, 0, 2, 0);
		trial(6'h06, 0, 2, 0, M, L, L, L, 0, 0, 0, 0);
		trial(6'h04, 0, 2, 0, M, L, L, L, 1, 0, 2, 0);
		trial(6'h11, 0, 2, 0, L, L, L, L, 1, 0, 2, 0);
		for (int k = 0; k < 4; k++) begin
			op = k[1:0];
			trial(6'h20, 0, 2, 0, ma[k], ea[k], mb[k], eb[k], 1, 0, 2, 0);
		end
		op = 2'h1;
		trial(6'h20, 0, 2, 0, H, L, H, H, 0, 0, 0, 0);
		trial(6'h00, 32'hFFFFFFE0, 32, 40, L, L, H, L, 1, 31, 0, 0);
		clk_mode = 2'h2;
		trial(6'h00, 32'h00000014, 2, 0, L, L, H, L, 1, 0, 2, 16);
		chk("clock select", csel, 2'h2);
		s_div4;
		wrap_up;
	end
endmodule // atc_trig_ctrl_tb

`default_nettype wire
